/* File: pkg/csp_pkg.sv */
package csp_pkg;

  // ==========================================================================
  // Register map.
  // ==========================================================================
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_CS_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_OTP_PROGRAM = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_FAULT_STATE = 4'h4;

  // ==========================================================================
  // Field positions of the current-sense configuration register.
  // ==========================================================================
  localparam int POS_OCP_LATCH = 8;
  localparam int POS_SENSE_MODE = 9;
  localparam int POS_BRAKE = 10;
  localparam int POS_TRUNC_DIS = 11;
  localparam int POS_REF_SEL = 12;
  localparam int POS_NEG_DIS = 13;
  localparam int POS_AZ_LO = 14;
  localparam int POS_AZ_HI = 15;
  localparam logic [15:0] CS_CONFIG_RESET = 16'h0833;

  // ==========================================================================
  // Field positions of the OTP program register.
  // ==========================================================================
  localparam int POS_PROG = 0;
  localparam int POS_TAG_LO = 1;
  localparam int POS_TAG_HI = 4;
  localparam logic [3:0] USER_TAG_RESET = 4'h0;

  // ==========================================================================
  // Interrupt status bits.
  // ==========================================================================
  localparam int IRQ_W = 3;
  localparam int IRQ_POS_OCP = 0;
  localparam int IRQ_NEG_OCP = 1;
  localparam int IRQ_PROG_DONE = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Auto-zero field encodings.
  typedef enum logic [1:0] {
    CSP_AZ_INTERNAL = 2'h0,
    CSP_AZ_OFF = 2'h1,
    CSP_AZ_EXTERNAL = 2'h2,
    CSP_AZ_EXT_CPGATE = 2'h3
  } csp_az_t;

endpackage

/* File: logic/csp_az_decode.sv */
`timescale 1ns/1ps
// ==========================================================================
// Auto-zero mode decode, registered.
// ==========================================================================
module csp_az_decode
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_mode,
  output logic o_enable,
  output logic o_external_sync,
  output logic o_cp_clock_gate
);

  wire next_enable;
  wire next_external_sync;
  wire next_cp_clock_gate;

  // Only the off code disables; both upper codes take the external sync.
  assign next_enable = (i_mode != csp_pkg::CSP_AZ_OFF);
  assign next_external_sync = i_mode[1];
  assign next_cp_clock_gate = (i_mode == csp_pkg::CSP_AZ_EXT_CPGATE);

  // Registered so the top outputs come straight from flip-flops.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_enable <= 1'b1;
      o_external_sync <= 1'b0;
      o_cp_clock_gate <= 1'b0;
    end
    else
    begin
      o_enable <= next_enable;
      o_external_sync <= next_external_sync;
      o_cp_clock_gate <= next_cp_clock_gate;
    end
  end

endmodule

/* File: logic/csp_sync.sv */
`timescale 1ns/1ps
// ==========================================================================
// Three-stage synchroniser; a change counts once stages two and three agree.
// ==========================================================================
module csp_sync
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_level
);

  logic [2:0] stage;

  // The first stage feeds only the second, keeping metastability contained.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      stage <= 3'h0;
      o_level <= 1'b0;
    end
    else
    begin
      stage <= {stage[1:0], i_async};
      if (stage[1] == stage[2])
      begin
        o_level <= stage[2];
      end
    end
  end

endmodule

/* File: logic/csp_regs.sv */
`timescale 1ns/1ps
// What this block does
// - Bit 8 of the sense configuration selects an unlatched (0) or latched (1) overcurrent fault.
// - Bit 9 selects shunt sensing at 0, and at 1 on-resistance sensing with sampling forced to low-side gate on only.
// - Bit 10 at 1 makes an overcurrent fault request braking and forces it latched; at 0 there is no braking.
// - Bit 11 at 1 stops PWM truncation on overcurrent while fault triggering stays unchanged.
// - Bit 12 selects the internal offset reference at 0 and the external reference pin at 1.
// - Bit 13 at 1 suppresses negative overcurrent truncation and fault reporting entirely.
// - Bits 15:14 pick auto-zero internal sync, off, external sync, or external sync with charge pump gating.
// - Writing 1 to bit 0 of the OTP program register starts OTP programming; the bit is write-only.
// - Bits 4:1 of the OTP program register hold a read-write user version tag for the OTP.
// - Bits 15:5 of the OTP program register read as zero and ignore writes.
module csp_regs
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [csp_pkg::ADDR_W-1:0] i_addr,
  input wire logic [csp_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [csp_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_pos_ocp,
  input wire logic i_neg_ocp,
  input wire logic i_low_side_gate,
  input wire logic i_prog_done,
  input wire logic i_fault_clear,
  output logic o_ocp_fault,
  output logic o_neg_ocp_fault,
  output logic o_truncate_pwm,
  output logic o_brake_request,
  output logic o_sense_rdson,
  output logic o_sense_sample_en,
  output logic o_reference_external,
  output logic o_az_enable,
  output logic o_az_external_sync,
  output logic o_cp_clock_gate,
  output logic o_nvm_program_trigger,
  output logic [3:0] o_user_version_tag,
  output logic o_irq
);

  // ==========================================================================
  // Storage.
  // ==========================================================================
  logic [csp_pkg::DATA_W-1:0] cs_config;
  logic [3:0] user_version_tag;
  logic [csp_pkg::IRQ_W-1:0] irq_status;
  logic [csp_pkg::IRQ_W-1:0] irq_mask;
  logic ocp_hold;
  logic neg_hold;
  logic pos_sync;
  logic neg_sync;
  logic gate_sync;
  logic done_sync;
  logic done_prev;

  // ==========================================================================
  // Pin synchronisers: the sense comparators and gate come from analog land.
  // ==========================================================================
  // A pin level must hold at least two clock cycles to count; shorter glitches are dropped.
  // Each path adds about four cycles before the field logic sees a change.
  csp_sync u_sync_pos
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(i_pos_ocp),
    .o_level(pos_sync)
  );

  csp_sync u_sync_neg
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(i_neg_ocp),
    .o_level(neg_sync)
  );

  csp_sync u_sync_gate
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(i_low_side_gate),
    .o_level(gate_sync)
  );

  csp_sync u_sync_done
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(i_prog_done),
    .o_level(done_sync)
  );

  // ==========================================================================
  // Field views and decode.
  // ==========================================================================
  wire ocp_latch_select = cs_config[csp_pkg::POS_OCP_LATCH];
  wire sense_mode = cs_config[csp_pkg::POS_SENSE_MODE];
  wire brake_on_overcurrent = cs_config[csp_pkg::POS_BRAKE];
  wire truncation_disable = cs_config[csp_pkg::POS_TRUNC_DIS];
  wire reference_source_select = cs_config[csp_pkg::POS_REF_SEL];
  wire negative_overcurrent_disable = cs_config[csp_pkg::POS_NEG_DIS];
  wire [1:0] auto_zero_mode = cs_config[csp_pkg::POS_AZ_HI:csp_pkg::POS_AZ_LO];

  wire wr_cfg = i_wr && (i_addr == csp_pkg::ADDR_CS_CONFIG);
  wire wr_otp = i_wr && (i_addr == csp_pkg::ADDR_OTP_PROGRAM);
  wire wr_irq_status = i_wr && (i_addr == csp_pkg::ADDR_IRQ_STATUS);
  wire wr_irq_mask = i_wr && (i_addr == csp_pkg::ADDR_IRQ_MASK);

  // Braking forces latching, so either bit makes the fault sticky.
  wire fault_latched = ocp_latch_select | brake_on_overcurrent;
  // The negative path is gated off entirely when disabled.
  wire neg_event = neg_sync & ~negative_overcurrent_disable;
  // Fault triggering ignores the truncation-disable bit.
  wire next_ocp_fault = pos_sync | neg_event | (fault_latched & ocp_hold);
  // A disabled negative path drops even a latched negative fault.
  wire neg_keep = fault_latched & neg_hold & ~negative_overcurrent_disable;
  wire next_neg_fault = neg_event | neg_keep;
  // Truncation follows the live comparators, never the latched copy.
  wire next_truncate = (pos_sync | neg_event) & ~truncation_disable;
  wire next_brake = brake_on_overcurrent & next_ocp_fault;
  // On-resistance sensing only samples while the low-side gate is on.
  wire next_sample_en = ~sense_mode | gate_sync;
  wire prog_pulse = wr_otp & i_wdata[csp_pkg::POS_PROG];
  wire done_rise = done_sync & ~done_prev;

  wire [csp_pkg::IRQ_W-1:0] irq_events;
  assign irq_events[csp_pkg::IRQ_POS_OCP] = pos_sync & ~ocp_hold;
  assign irq_events[csp_pkg::IRQ_NEG_OCP] = neg_event & ~neg_hold;
  assign irq_events[csp_pkg::IRQ_PROG_DONE] = done_rise;

  // Bits written as one clear their flag; bits written as zero leave it alone.
  wire [csp_pkg::IRQ_W-1:0] irq_clear = wr_irq_status ? i_wdata[csp_pkg::IRQ_W-1:0] : 3'h0;

  // Program bit and reserved bits read as zero; only the tag is visible.
  wire [csp_pkg::DATA_W-1:0] otp_view = {11'h000, user_version_tag, 1'b0};
  wire [csp_pkg::DATA_W-1:0] fault_view = {13'h0000, o_brake_request, neg_hold, ocp_hold};

  // Unmapped addresses read as zero.
  wire [csp_pkg::DATA_W-1:0] next_rdata =
    (i_addr == csp_pkg::ADDR_CS_CONFIG) ? cs_config :
    (i_addr == csp_pkg::ADDR_OTP_PROGRAM) ? otp_view :
    (i_addr == csp_pkg::ADDR_IRQ_STATUS) ? {13'h0000, irq_status} :
    (i_addr == csp_pkg::ADDR_IRQ_MASK) ? {13'h0000, irq_mask} :
    (i_addr == csp_pkg::ADDR_FAULT_STATE) ? fault_view : 16'h0000;

  // ==========================================================================
  // Configuration registers.
  // ==========================================================================
  // Whole-word writes; the threshold bits below 8 are held for the analog side.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cs_config <= csp_pkg::CS_CONFIG_RESET;
    end
    else if (wr_cfg)
    begin
      cs_config <= i_wdata;
    end
  end

  // Only the tag is stored; the program bit is a strobe and the rest is reserved.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      user_version_tag <= csp_pkg::USER_TAG_RESET;
    end
    else if (wr_otp)
    begin
      user_version_tag <= i_wdata[csp_pkg::POS_TAG_HI:csp_pkg::POS_TAG_LO];
    end
  end

  // Read port: data stands only in the cycle after the strobe.
  // Reads have no side effects, so reading the status never clears a flag.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_rdata <= 16'h0000;
    end
    else
    begin
      o_rdata <= i_rd ? next_rdata : 16'h0000;
    end
  end

  // ==========================================================================
  // Fault state.
  // ==========================================================================
  // A latched fault holds until cleared; a clear loses to a live comparator.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ocp_hold <= 1'b0;
    end
    else
    begin
      ocp_hold <= i_fault_clear ? (pos_sync | neg_event) : next_ocp_fault;
    end
  end

  // The negative copy feeds its own output and the fault view.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      neg_hold <= 1'b0;
    end
    else
    begin
      neg_hold <= i_fault_clear ? neg_event : next_neg_fault;
    end
  end

  // ==========================================================================
  // Registered outputs.
  // ==========================================================================
  // Fault outputs registered to keep glitches off the gate driver.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_ocp_fault <= 1'b0;
      o_neg_ocp_fault <= 1'b0;
      o_truncate_pwm <= 1'b0;
      o_brake_request <= 1'b0;
    end
    else
    begin
      o_ocp_fault <= ocp_hold;
      o_neg_ocp_fault <= neg_hold;
      o_truncate_pwm <= next_truncate;
      o_brake_request <= next_brake;
    end
  end

  // Sense front-end controls; sampling stays on throughout shunt mode.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_sense_rdson <= 1'b0;
      o_sense_sample_en <= 1'b1;
      o_reference_external <= 1'b0;
    end
    else
    begin
      o_sense_rdson <= sense_mode;
      o_sense_sample_en <= next_sample_en;
      o_reference_external <= reference_source_select;
    end
  end

  // Copy of the stored tag for the OTP sequencer.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_user_version_tag <= csp_pkg::USER_TAG_RESET;
    end
    else
    begin
      o_user_version_tag <= user_version_tag;
    end
  end

  // One clean pulse per write of 1; never readable, never held.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_nvm_program_trigger <= 1'b0;
    end
    else
    begin
      o_nvm_program_trigger <= prog_pulse;
    end
  end

  csp_az_decode u_az
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_mode(auto_zero_mode),
    .o_enable(o_az_enable),
    .o_external_sync(o_az_external_sync),
    .o_cp_clock_gate(o_cp_clock_gate)
  );

  // ==========================================================================
  // Interrupts.
  // ==========================================================================
  // Write one to clear; a new event in the same cycle wins over the clear.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      irq_status <= 3'h0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
    end
  end

  // Mask bits share the status layout; every event starts masked.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      irq_mask <= csp_pkg::IRQ_MASK_RESET;
    end
    else if (wr_irq_mask)
    begin
      irq_mask <= i_wdata[csp_pkg::IRQ_W-1:0];
    end
  end

  // Previous done level; it resets to the idle level so no false edge follows reset.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      done_prev <= 1'b0;
    end
    else
    begin
      done_prev <= done_sync;
    end
  end

  // Level interrupt, registered so the pin comes straight from a flip-flop.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

endmodule

/* File: tb/csp_regs_props.sv */
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the sense and OTP register block.
// ==========================================================================
module csp_regs_props
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_neg_ocp_fault,
  input wire logic o_sense_rdson,
  input wire logic o_sense_sample_en,
  input wire logic o_reference_external,
  input wire logic o_az_enable,
  input wire logic o_az_external_sync,
  input wire logic o_cp_clock_gate,
  input wire logic o_nvm_program_trigger,
  input wire logic [3:0] o_user_version_tag
);
  // Decoded strobes and the field values a write carries.
  wire cfg_wr = i_wr && i_addr == csp_pkg::ADDR_CS_CONFIG;
  wire otp_wr = i_wr && i_addr == csp_pkg::ADDR_OTP_PROGRAM;
  wire otp_rd = i_rd && i_addr == csp_pkg::ADDR_OTP_PROGRAM;
  wire prog_wr = otp_wr && i_wdata[0];
  wire [3:0] w_tag = i_wdata[4:1];
  wire w_rdson = i_wdata[9];
  wire w_ref = i_wdata[12];
  wire [2:0] w_az = {i_wdata[15:14] != 2'h1, i_wdata[15], &i_wdata[15:14]};

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ==========================================================================
  // Config fields reach their outputs two edges after the write; the negative disable reaches o_neg_ocp_fault after three.
  // ==========================================================================
  a_rdson_follow: assert property
    (cfg_wr |=> ##1 o_sense_rdson == $past(w_rdson, 2)) else $error("sense mode wrong");
  a_sample_gate: assert property
    (!o_sense_rdson |-> o_sense_sample_en) else $error("shunt mode gated sampling");
  a_ref_follow: assert property
    (cfg_wr |=> ##1 o_reference_external == $past(w_ref, 2)) else $error("ref select wrong");
  a_az_decode: assert property
    (cfg_wr |=> ##1 {o_az_enable, o_az_external_sync, o_cp_clock_gate} == $past(w_az, 2))
    else $error("auto-zero decode wrong");
  a_neg_off: assert property
    (cfg_wr && i_wdata[13] |=> ##2 !o_neg_ocp_fault) else $error("neg fault while disabled");

  // ==========================================================================
  // OTP register: one trigger per write of one, tag loads, reads masked.
  // ==========================================================================
  a_trig_pulse: assert property
    (prog_wr |=> o_nvm_program_trigger) else $error("program pulse missing");
  a_trig_cause: assert property
    (o_nvm_program_trigger |-> $past(prog_wr)) else $error("program pulse without write");
  a_tag_load: assert property
    (otp_wr |=> ##1 o_user_version_tag == $past(w_tag, 2)) else $error("user tag wrong");
  a_otp_read: assert property
    ($past(otp_rd) |-> o_rdata[15:5] == 11'h0 && !o_rdata[0]) else $error("otp read bits set");
endmodule

bind csp_regs csp_regs_props i_csp_regs_props (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .o_neg_ocp_fault, .o_sense_rdson, .o_sense_sample_en,
  .o_reference_external, .o_az_enable, .o_az_external_sync, .o_cp_clock_gate,
  .o_nvm_program_trigger, .o_user_version_tag);

/* File: tb/csp_regs_tb.sv */
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the sense and OTP register block.
// ==========================================================================
module csp_regs_tb;
  logic i_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0;
  logic i_pos_ocp = 1'b0, i_neg_ocp = 1'b0, i_low_side_gate = 1'b0;
  logic i_prog_done = 1'b0, i_fault_clear = 1'b0;
  logic [15:0] o_rdata;
  logic o_ocp_fault, o_neg_ocp_fault, o_truncate_pwm, o_brake_request, o_sense_rdson;
  logic o_sense_sample_en, o_reference_external, o_az_enable, o_az_external_sync;
  logic o_cp_clock_gate, o_nvm_program_trigger, o_irq;
  logic [3:0] o_user_version_tag;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  logic [15:0] d;
  logic g, p, n;
  logic [3:0] e;

  csp_regs i_csp_regs (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_pos_ocp, .i_neg_ocp, .i_low_side_gate, .i_prog_done, .i_fault_clear, .o_ocp_fault,
    .o_neg_ocp_fault, .o_truncate_pwm, .o_brake_request, .o_sense_rdson, .o_sense_sample_en,
    .o_reference_external, .o_az_enable, .o_az_external_sync, .o_cp_clock_gate,
    .o_nvm_program_trigger, .o_user_version_tag, .o_irq);

  // Clock, and a cycle ceiling so a hang still ends in the report.
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================================
  // Helpers: compare, bus cycles and expectations.
  // ==========================================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic pins(input logic a, input logic b);
    @(posedge i_clk);
    i_pos_ocp <= a;
    i_neg_ocp <= b;
    tick(8);
  endtask
  function automatic logic [2:0] azx(input logic [1:0] m);
    return {m != 2'h1, m[1], &m};
  endfunction
  // Pins still high (h=0) or released (h=1); a released fault stays only if latched.
  function automatic logic [3:0] flt(input logic [15:0] c, input logic a, b, h);
    logic f;
    f = (a | (b & ~c[13])) & (h ? (c[8] | c[10]) : 1'b1);
    return {f, f & ~h & ~c[11], f & c[10], b & ~c[13] & (h ? (c[8] | c[10]) : 1'b1)};
  endfunction
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial
  begin
    void'($urandom(32'h5443c2ec));
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    #1 chk(o_az_enable, 1'b1);
    chk(o_sense_sample_en, 1'b1);
    rd(csp_pkg::ADDR_CS_CONFIG, csp_pkg::CS_CONFIG_RESET);
    rd(csp_pkg::ADDR_OTP_PROGRAM, 16'h0);
    rd(4'hf, 16'h0);
    // Every auto-zero code twice, with random other fields and gate level.
    for (int i = 0; i < 8; i++)
    begin
      d = {i[1:0], 14'($urandom)};
      g = 1'($urandom);
      @(posedge i_clk);
      i_low_side_gate <= g;
      wr(csp_pkg::ADDR_CS_CONFIG, d);
      tick(6);
      chk(o_sense_rdson, d[9]);
      chk(o_sense_sample_en, 1'(~d[9] | g));
      chk(o_reference_external, d[12]);
      chk({o_az_enable, o_az_external_sync, o_cp_clock_gate}, azx(d[15:14]));
      rd(csp_pkg::ADDR_CS_CONFIG, d);
    end
    // Random words into the OTP register, program bit alternating.
    for (int i = 0; i < 6; i++)
    begin
      d = 16'($urandom);
      d[0] = i[0];
      wr(csp_pkg::ADDR_OTP_PROGRAM, d);
      #1 chk(o_nvm_program_trigger, d[0]);
      tick(1);
      chk(o_nvm_program_trigger, 1'b0);
      chk(o_user_version_tag, d[4:1]);
      rd(csp_pkg::ADDR_OTP_PROGRAM, {11'h0, d[4:1], 1'b0});
    end
    // Fault behaviour with only the positive event unmasked.
    wr(csp_pkg::ADDR_IRQ_STATUS, 16'h7);
    wr(csp_pkg::ADDR_IRQ_MASK, 16'h1);
    for (int i = 0; i < 10; i++)
    begin
      d = 16'($urandom) & 16'h2d00;
      p = 1'($urandom);
      n = ~p | 1'($urandom);
      if (i < 2)
      begin
        d = i ? 16'h0400 : 16'h2000;
        p = i[0];
        n = ~p;
      end
      wr(csp_pkg::ADDR_CS_CONFIG, d);
      pins(p, n);
      e = flt(d, p, n, 1'b0);
      chk({o_ocp_fault, o_truncate_pwm, o_brake_request, o_neg_ocp_fault}, e);
      pins(1'b0, 1'b0);
      e = flt(d, p, n, 1'b1);
      chk({o_ocp_fault, o_truncate_pwm, o_brake_request, o_neg_ocp_fault}, e);
      rd(csp_pkg::ADDR_FAULT_STATE, {13'h0, e[1], e[0], e[3]});
      chk(o_irq, p);
      @(posedge i_clk);
      i_fault_clear <= 1'b1;
      @(posedge i_clk);
      i_fault_clear <= 1'b0;
      wr(csp_pkg::ADDR_IRQ_STATUS, 16'h7);
      tick(3);
      chk({o_ocp_fault, o_irq}, 2'h0);
    end
    // Programming done event through status and mask.
    @(posedge i_clk);
    i_prog_done <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_prog_done <= 1'b0;
    tick(6);
    chk(o_irq, 1'b0);
    rd(csp_pkg::ADDR_IRQ_STATUS, 16'h4);
    wr(csp_pkg::ADDR_IRQ_MASK, 16'h4);
    tick(3);
    chk(o_irq, 1'b1);
    rd(csp_pkg::ADDR_IRQ_MASK, 16'h4);
    summarize();
  end
endmodule
